// *** core/jogc_core.sv ***
`default_nettype none
module jogc_core
    import jogc_pkg::*;
#(
    parameter int AXES          = 32,
    parameter bit SMALL_VARIANT = 1'b0
) (
    input  wire logic                        CLOCK,
    input  wire logic                        RESET,
    input  wire jogc_pkg::jogc_wb_req_t      WB_REQ,
    output logic                             WB_ACK,
    output logic [31:0]                      WB_DAT_O,
    input  wire logic                        TEST_MODE,
    input  wire logic [AXES-1:0]             AXIS_BUSY,
    output logic [AXES-1:0]                  RUN_FWD,
    output logic [AXES-1:0]                  RUN_REV,
    output logic [AXES-1:0]                  DECEL_REQ,
    output jogc_pkg::jogc_speed_t [AXES-1:0] AXIS_SPEED
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [13:0] idx_of(input logic [13:0] base, input logic [13:0] stride,
                                           input int n);
        idx_of = base + 14'(stride * 14'(n));
    endfunction

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic            test_m;
    logic            test_s;
    logic [AXES-1:0] busy_m;
    logic [AXES-1:0] busy_s;

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            test_m <= 1'b0;
            test_s <= 1'b0;
            busy_m <= '0;
            busy_s <= '0;
        end else begin
            test_m <= TEST_MODE;
            test_s <= test_m;
            busy_m <= AXIS_BUSY;
            busy_s <= busy_m;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    wire             wb_go = WB_REQ.cyc && WB_REQ.stb && !WB_ACK;
    // Write lands at the edge where the master samples ack
    wire             wr    = WB_REQ.cyc && WB_REQ.stb && WB_REQ.we && WB_ACK;
    wire [13:0]      idx   = WB_REQ.adr[ADR_W-1:2];
    wire             hit_group = (idx == GROUP_IDX);
    logic [31:0]     rd_data;
    logic            grp_cmd;
    logic            grp_arm;
    logic [15:0]     sel_word [SEL_WORDS];
    logic [AXES-1:0] cmd_f;
    logic [AXES-1:0] cmd_r;
    logic [15:0]     spd_lo [AXES];
    logic [15:0]     spd_hi [AXES];
    logic [AXES-1:0] hit_cmd;
    logic [AXES-1:0] hit_lo;
    logic [AXES-1:0] hit_hi;
    logic [SEL_WORDS-1:0] hit_sel;
    wire [31:0]      sel_f_all = {sel_word[1], sel_word[0]};
    wire [31:0]      sel_r_all = {sel_word[3], sel_word[2]};
    wire             grp_start = grp_cmd && grp_arm && !test_s;

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            WB_ACK   <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            WB_ACK   <= wb_go;
            WB_DAT_O <= rd_data;
        end
    end

    always_comb begin
        rd_data = '0;
        if (hit_group) begin
            rd_data[GROUP_START_BIT] = grp_cmd;
        end else if (idx == STATUS_IDX) begin
            for (int i = 0; i < AXES; i++) rd_data[i] = RUN_FWD[i] | RUN_REV[i] | DECEL_REQ[i];
        end else if (|hit_sel) begin
            for (int i = 0; i < SEL_WORDS; i++)
                if (hit_sel[i]) rd_data[15:0] = sel_word[i];
        end else begin
            for (int i = 0; i < AXES; i++) begin
                if (hit_cmd[i]) begin
                    rd_data[CMD_FWD_BIT] = cmd_f[i];
                    rd_data[CMD_REV_BIT] = cmd_r[i];
                end
                if (hit_lo[i]) rd_data[15:0] = spd_lo[i];
                if (hit_hi[i]) rd_data[15:0] = spd_hi[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Group command and axis selection
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            grp_cmd <= 1'b0;
            grp_arm <= 1'b0;
        end else begin
            if (wr && hit_group && WB_REQ.sel[0]) grp_cmd <= WB_REQ.dat[GROUP_START_BIT];
            grp_arm <= !test_s && !grp_cmd;
        end
    end

    for (genvar w = 0; w < SEL_WORDS; w++) begin : g_sel
        assign hit_sel[w] = (idx == idx_of(SEL_BASE_IDX, 14'h001, w));
        always_ff @(posedge CLOCK or posedge RESET) begin
            if (RESET) sel_word[w] <= WORD_RESET;
            else if (wr && hit_sel[w]) sel_word[w] <= merge16(sel_word[w], WB_REQ.dat, WB_REQ.sel);
        end
    end

    // ------------------------------------------------------------
    // Per-axis jog control
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    for (genvar n = 0; n < AXES; n++) begin : g_axis
        localparam bit OK = !SMALL_VARIANT || (n < SMALL_AXES);
        jogc_state_t st;
        jogc_state_t next_st;
        logic        grp;
        logic        arm_f;
        logic        arm_r;
        logic [2:0]  cnt;
        wire [13:0]  lo_idx  = idx_of(SPEED_BASE_IDX, SPEED_STRIDE, n);
        wire         start_f = OK && cmd_f[n] && arm_f && !test_s;
        wire         start_r = OK && cmd_r[n] && arm_r && !test_s;
        wire         gstart  = OK && grp_start && (sel_f_all[n] || sel_r_all[n]);
        wire         hold    = grp ? grp_cmd : ((st == ST_FWD) ? cmd_f[n] : cmd_r[n]);
        wire         leaving = (st == ST_DECEL) || (next_st == ST_DECEL);
        wire         next_grp = (st == ST_IDLE) ? (!start_f && !start_r && gstart) : grp;

        assign hit_cmd[n] = OK && (idx == idx_of(CMD_BASE_IDX, CMD_STRIDE, n));
        assign hit_lo[n]  = OK && (idx == lo_idx);
        assign hit_hi[n]  = OK && (idx == lo_idx + SPEED_HI_OFS);

        always_ff @(posedge CLOCK or posedge RESET) begin
            if (RESET) begin
                cmd_f[n]  <= 1'b0;
                cmd_r[n]  <= 1'b0;
                spd_lo[n] <= WORD_RESET;
                spd_hi[n] <= WORD_RESET;
            end else if (wr) begin
                if (hit_cmd[n] && WB_REQ.sel[0]) begin
                    cmd_f[n] <= WB_REQ.dat[CMD_FWD_BIT];
                    cmd_r[n] <= WB_REQ.dat[CMD_REV_BIT];
                end
                if (hit_lo[n]) spd_lo[n] <= merge16(spd_lo[n], WB_REQ.dat, WB_REQ.sel);
                if (hit_hi[n]) spd_hi[n] <= merge16(spd_hi[n], WB_REQ.dat, WB_REQ.sel);
            end
        end

        always_comb begin
            next_st = st;
            case (st)
                ST_IDLE: begin
                    if (start_f) next_st = ST_FWD;
                    else if (start_r) next_st = ST_REV;
                    else if (gstart) next_st = sel_f_all[n] ? ST_FWD : ST_REV;
                end
                ST_FWD, ST_REV: begin
                    if (!hold || test_s) next_st = ST_DECEL;
                end
                ST_DECEL: begin
                    if (cnt == DECEL_SETTLE && !busy_s[n]) next_st = ST_IDLE;
                end
                default: next_st = ST_IDLE;
            endcase
        end

        always_ff @(posedge CLOCK or posedge RESET) begin
            if (RESET) begin
                st            <= ST_IDLE;
                grp           <= 1'b0;
                arm_f         <= 1'b0;
                arm_r         <= 1'b0;
                cnt           <= '0;
                RUN_FWD[n]    <= 1'b0;
                RUN_REV[n]    <= 1'b0;
                DECEL_REQ[n]  <= 1'b0;
                AXIS_SPEED[n] <= '0;
            end else begin
                st            <= next_st;
                grp           <= next_grp;
                arm_f         <= !(test_s || leaving) && (!cmd_f[n] || arm_f);
                arm_r         <= !(test_s || leaving) && (!cmd_r[n] || arm_r);
                cnt           <= (st != ST_DECEL) ? '0 : (cnt == DECEL_SETTLE) ? cnt : cnt + 3'h1;
                RUN_FWD[n]    <= (next_st == ST_FWD);
                RUN_REV[n]    <= (next_st == ST_REV);
                DECEL_REQ[n]  <= (next_st == ST_DECEL);
                if (st == ST_IDLE && next_st != ST_IDLE)
                    AXIS_SPEED[n] <= {spd_hi[n], spd_lo[n]};
            end
        end

        // --------------------------------------------------------
        // Checks
        // --------------------------------------------------------
        sequence s_fwd_released;
            st == ST_FWD && !grp && !cmd_f[n];
        endsequence
        property p_hold;
            (st == ST_FWD && !grp && cmd_f[n] && !test_s) |=> (st == ST_FWD) && RUN_FWD[n];
        endproperty
        a_hold: assert property (p_hold) else $error("held forward jog stopped");
        property p_release;
            s_fwd_released |=> (st == ST_DECEL) ##1 (DECEL_REQ[n] && !RUN_FWD[n]);
        endproperty
        a_release: assert property (p_release) else $error("release gave no decel");
        property p_cmd_write;
            (wr && hit_cmd[n] && WB_REQ.sel[0]) |=> cmd_f[n] == $past(WB_REQ.dat[CMD_FWD_BIT]);
        endproperty
        a_cmd_write: assert property (p_cmd_write) else $error("command bit not stored");
        property p_invalid;
            !OK |-> (st == ST_IDLE && !RUN_FWD[n] && !RUN_REV[n]);
        endproperty
        a_invalid: assert property (p_invalid) else $error("invalid axis moved");
        property p_both;
            (st == ST_IDLE && start_f && start_r) |=> (st == ST_FWD) ##1 !RUN_REV[n];
        endproperty
        a_both: assert property (p_both) else $error("forward did not win");
        property p_no_rev;
            (st == ST_DECEL && $past(st) == ST_FWD && cmd_r[n]) |=> !arm_r;
        endproperty
        a_no_rev: assert property (p_no_rev) else $error("held reverse rearmed");
        property p_redecel;
            (st == ST_DECEL && cmd_f[n]) ##1 (st == ST_IDLE && cmd_f[n]) |=> st != ST_FWD;
        endproperty
        a_redecel: assert property (p_redecel) else $error("restart after decel");
        property p_test;
            test_s |=> (!arm_f && !arm_r && st != ST_FWD && st != ST_REV) or $past(st != ST_IDLE);
        endproperty
        a_test: assert property (p_test) else $error("jog accepted in test mode");
        property p_group;
            (st == ST_IDLE && !start_f && !start_r && gstart && sel_f_all[n]) |=> (st == ST_FWD && grp);
        endproperty
        a_group: assert property (p_group) else $error("group axis not started");
        property p_unselected;
            (st == ST_IDLE && grp_start && !sel_f_all[n] && !sel_r_all[n] && !start_f && !start_r)
                |=> st == ST_IDLE;
        endproperty
        a_unselected: assert property (p_unselected) else $error("unselected axis ran");
        property p_speed;
            (st == ST_IDLE && next_st != ST_IDLE) |=> AXIS_SPEED[n] == $past({spd_hi[n], spd_lo[n]});
        endproperty
        a_speed: assert property (p_speed) else $error("speed not sampled at start");
    end

endmodule // jogc_core
`default_nettype wire

// *** core/jogc_pkg.sv ***
`default_nettype none
package jogc_pkg;

    // ------------------------------------------------------------
    // Register map, word indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam int          IDX_W           = 14;
    localparam int          ADR_W           = 16;
    localparam logic [13:0] CMD_BASE_IDX    = 14'hC82;   // 3202
    localparam logic [13:0] CMD_STRIDE      = 14'h014;   // 20
    localparam logic [13:0] SPEED_BASE_IDX  = 14'h280;   // 640
    localparam logic [13:0] SPEED_STRIDE    = 14'h002;
    localparam logic [13:0] SPEED_HI_OFS    = 14'h001;
    localparam logic [13:0] SEL_BASE_IDX    = 14'h2C6;   // 710
    localparam int          SEL_WORDS       = 4;
    localparam logic [13:0] GROUP_IDX       = 14'h800;   // 2048
    localparam logic [13:0] STATUS_IDX      = 14'h100;

    // ------------------------------------------------------------
    // Field positions and limits
    // ------------------------------------------------------------
    localparam int          CMD_FWD_BIT     = 0;
    localparam int          CMD_REV_BIT     = 1;
    localparam int          GROUP_START_BIT = 0;
    localparam int          MAX_AXES        = 32;
    localparam int          SMALL_AXES      = 8;
    localparam logic [2:0]  DECEL_SETTLE    = 3'h4;
    localparam logic [15:0] WORD_RESET      = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [31:0] jogc_speed_t;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [3:0]       sel;
        logic [31:0]      dat;
    } jogc_wb_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FWD,
        ST_REV,
        ST_DECEL
    } jogc_state_t;

endpackage
`default_nettype wire

// *** testbench/jogc_host.sv ***
`default_nettype none
module jogc_host
    import jogc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              ack,
    input  wire logic [31:0]       rdat,
    output jogc_pkg::jogc_wb_req_t req
);
    timeunit 1ns;
    timeprecision 100ps;
    int          timeouts = 0;
    logic [31:0] last_rd;
    initial req = '0;
    // ------------------------------------------------------------
    // Classic single cycle, held until ack
    // ------------------------------------------------------------
    task automatic cycle(input logic w, input logic [15:0] a, input logic [31:0] d,
                         input logic [3:0] s = 4'h3);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) timeouts++;
        last_rd = rdat;
        req <= '0;
    endtask
    function automatic logic [15:0] widx(input int i);
        return 16'(i * 4);
    endfunction
    // ------------------------------------------------------------
    // Host program helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] scaled(input int v, input bit per_hundred);
        return per_hundred ? 32'(v * 100) : 32'(v * 1000);
    endfunction
    task automatic set_speed(input int n, input logic [31:0] s);
        cycle(1'b1, widx(int'(SPEED_BASE_IDX) + 2 * n), {16'h0000, s[15:0]});
        cycle(1'b1, widx(int'(SPEED_BASE_IDX) + 2 * n + 1), {16'h0000, s[31:16]});
    endtask
    task automatic set_cmd(input int n, input logic [1:0] c);
        cycle(1'b1, widx(int'(CMD_BASE_IDX) + 20 * n), {30'h0, c});
    endtask
endmodule // jogc_host
`default_nettype wire

// *** testbench/tb.sv ***
`default_nettype none
module tb;
    import jogc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic               clock;
    logic               reset;
    logic               test_mode;
    logic [31:0]        busy;
    jogc_wb_req_t       wb_req;
    logic               wb_ack;
    logic [31:0]        wb_dat;
    logic [31:0]        run_fwd;
    logic [31:0]        run_rev;
    logic [31:0]        decel_req;
    jogc_speed_t [31:0] axis_speed;
    logic [31:0]        rd;
    int                 fails = 0;
    int                 cmp_count = 0;
    jogc_core #(.AXES(32), .SMALL_VARIANT(1'b1)) jogc_core_i (
        .CLOCK(clock), .RESET(reset), .WB_REQ(wb_req), .WB_ACK(wb_ack),
        .WB_DAT_O(wb_dat), .TEST_MODE(test_mode), .AXIS_BUSY(busy),
        .RUN_FWD(run_fwd), .RUN_REV(run_rev), .DECEL_REQ(decel_req),
        .AXIS_SPEED(axis_speed));
    jogc_host jogc_host_i (.clk(clock), .ack(wb_ack), .rdat(wb_dat), .req(wb_req));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic wait_stop();
        int n;
        n = 0;
        tick(1);
        while (decel_req !== 32'h0 && n < 100) begin
            tick(1);
            n++;
        end
        check(decel_req, 32'h0);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_fwd();
        check(jogc_host_i.scaled(6000, 1'b1), 32'h000927C0);
        check(jogc_host_i.scaled(50, 1'b0), 32'h0000C350);
        jogc_host_i.set_speed(0, jogc_host_i.scaled(6000, 1'b1));
        jogc_host_i.set_cmd(0, 2'h1);
        tick(2);
        check(run_fwd, 32'h1);
        jogc_host_i.set_speed(0, 32'h00012345);
        check(axis_speed[0], 32'h000927C0);
        jogc_host_i.cycle(1'b0, jogc_host_i.widx(256), 32'h0);
        check(jogc_host_i.last_rd, 32'h1);
        @(posedge clock);
        busy <= 32'h1;
        jogc_host_i.set_cmd(0, 2'h0);
        tick(1);
        check(run_fwd, 32'h0);
        tick(20);
        check(decel_req, 32'h1);
        @(posedge clock);
        busy <= 32'h0;
        wait_stop();
        check(axis_speed[0], 32'h000927C0);
    endtask
    task automatic t_both();
        jogc_host_i.set_cmd(1, 2'h3);
        tick(2);
        check(run_fwd, 32'h2);
        check(run_rev, 32'h0);
        jogc_host_i.set_cmd(1, 2'h2);
        wait_stop();
        tick(3);
        check(run_rev, 32'h0);
        jogc_host_i.set_cmd(1, 2'h0);
        jogc_host_i.set_cmd(1, 2'h2);
        tick(2);
        check(run_rev, 32'h2);
        jogc_host_i.set_cmd(1, 2'h0);
        wait_stop();
    endtask
    task automatic t_redecel();
        @(posedge clock);
        busy <= 32'h4;
        jogc_host_i.set_cmd(2, 2'h1);
        tick(2);
        jogc_host_i.set_cmd(2, 2'h0);
        jogc_host_i.set_cmd(2, 2'h1);
        check(run_fwd, 32'h0);
        @(posedge clock);
        busy <= 32'h0;
        wait_stop();
        tick(3);
        check(run_fwd, 32'h0);
        jogc_host_i.set_cmd(2, 2'h0);
        jogc_host_i.set_cmd(2, 2'h1);
        tick(2);
        check(run_fwd, 32'h4);
        jogc_host_i.set_cmd(2, 2'h0);
        wait_stop();
    endtask
    task automatic t_test();
        @(posedge clock);
        test_mode <= 1'b1;
        tick(4);
        jogc_host_i.set_cmd(3, 2'h1);
        tick(4);
        check(run_fwd, 32'h0);
        @(posedge clock);
        test_mode <= 1'b0;
        tick(4);
        check(run_fwd, 32'h0);
        jogc_host_i.set_cmd(3, 2'h0);
        jogc_host_i.set_cmd(3, 2'h1);
        tick(2);
        check(run_fwd, 32'h8);
        @(posedge clock);
        test_mode <= 1'b1;
        tick(4);
        check(decel_req, 32'h8);
        check(run_fwd, 32'h0);
        @(posedge clock);
        test_mode <= 1'b0;
        jogc_host_i.set_cmd(3, 2'h0);
        wait_stop();
    endtask
    task automatic t_group();
        jogc_host_i.set_speed(4, 32'h00011111);
        jogc_host_i.set_speed(5, 32'h00022222);
        jogc_host_i.cycle(1'b1, jogc_host_i.widx(710), 32'h00000010);
        jogc_host_i.cycle(1'b1, jogc_host_i.widx(712), 32'h00000020);
        jogc_host_i.cycle(1'b1, jogc_host_i.widx(2048), 32'h00000001);
        tick(2);
        check(run_fwd, 32'h10);
        check(run_rev, 32'h20);
        check(axis_speed[4], 32'h00011111);
        check(axis_speed[5], 32'h00022222);
        jogc_host_i.cycle(1'b0, jogc_host_i.widx(2048), 32'h0);
        check(jogc_host_i.last_rd, 32'h1);
        @(posedge clock);
        busy <= 32'h30;
        jogc_host_i.cycle(1'b1, jogc_host_i.widx(2048), 32'h00000000);
        tick(1);
        check(decel_req, 32'h30);
        tick(8);
        check(decel_req, 32'h30);
        @(posedge clock);
        busy <= 32'h0;
        wait_stop();
    endtask
    task automatic t_bus();
        jogc_host_i.set_cmd(8, 2'h1);
        tick(2);
        check(run_fwd, 32'h0);
        jogc_host_i.cycle(1'b0, jogc_host_i.widx(3202 + 160), 32'h0);
        check(jogc_host_i.last_rd, 32'h0);
        jogc_host_i.cycle(1'b0, jogc_host_i.widx(100), 32'h0);
        check(jogc_host_i.last_rd, 32'h0);
        jogc_host_i.cycle(1'b0, jogc_host_i.widx(640), 32'h0);
        check(jogc_host_i.last_rd, 32'h00002345);
        jogc_host_i.cycle(1'b1, jogc_host_i.widx(642), 32'h00001234);
        jogc_host_i.cycle(1'b1, jogc_host_i.widx(642), 32'h0000ABCD, 4'h1);
        jogc_host_i.cycle(1'b0, jogc_host_i.widx(642), 32'h0);
        check(jogc_host_i.last_rd, 32'h000012CD);
        jogc_host_i.cycle(1'b1, jogc_host_i.widx(3202 + 140), 32'h00000002, 4'h2);
        tick(2);
        check(run_rev, 32'h0);
        jogc_host_i.set_cmd(7, 2'h2);
        tick(2);
        check(run_rev, 32'h80);
        jogc_host_i.set_cmd(7, 2'h0);
        wait_stop();
    endtask
    // ------------------------------------------------------------
    // Clock, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        reset = 1'b1;
        test_mode = 1'b0;
        busy = 32'h0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        tick(3);
        t_fwd();
        t_both();
        t_redecel();
        t_test();
        t_group();
        t_bus();
        check(32'(jogc_host_i.timeouts), 32'h0);
        finish_test();
    end
    initial begin
        #3000000;
        fails++;
        finish_test();
    end
endmodule // tb
`default_nettype wire
